// ==== common/rph_pkg.sv ====
// Package for the root port hot-plug and event block
package rph_pkg;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [11:0] RPH_SLOT_CTL_OFS   = 12'h000;
  localparam logic [11:0] RPH_SLOT_STS_OFS   = 12'h004;
  localparam logic [11:0] RPH_MISC_CFG_OFS   = 12'h008;
  localparam logic [11:0] RPH_SMSC_STS_OFS   = 12'h00C;
  localparam logic [11:0] RPH_PORT_INFO_OFS  = 12'h010;
  localparam logic [11:0] RPH_ERR_CTL_OFS    = 12'h014;

  // Slot control fields
  localparam int RPH_PDE_BIT  = 3;
  localparam int RPH_HPE_BIT  = 5;
  // Slot status fields
  localparam int RPH_PDC_BIT  = 3;
  localparam int RPH_PDS_BIT  = 6;
  localparam int RPH_DLLA_BIT = 8;
  // Misc port config fields
  localparam int RPH_HPCE_BIT = 1;
  localparam int RPH_HPME_BIT = 2;
  // Sysmgmt / cfg-event status fields
  localparam int RPH_HPPDM_BIT = 1;
  localparam int RPH_HPLAS_BIT = 2;
  localparam int RPH_HPCS_BIT  = 3;
  // Port info fields
  localparam int RPH_SEPARATE_REFCLK_MODE_BIT   = 0;
  localparam int RPH_L0S_BIT    = 1;
  localparam int RPH_LSKP_BIT   = 2;
  localparam int RPH_REV_BIT    = 3;
  localparam int RPH_CFG_LSB    = 4;
  localparam int RPH_PPM_LSB    = 8;
  localparam int RPH_L1LAT_LSB  = 24;
  // Error control fields
  localparam int RPH_HDR_SYSTEM_ERROR_N_BIT = 0;
  localparam int RPH_CAP_SYSTEM_ERROR_N_BIT = 1;

  // Clock tolerance figures in ppm
  localparam logic [15:0] RPH_PPM_NORMAL = 16'd600;
  localparam logic [15:0] RPH_PPM_SEPARATE_REFCLK_MODE   = 16'd5600;

  // L1 exit latency encodings (capability field, 3 bits)
  localparam logic [2:0] RPH_L1LAT_NORMAL = 3'h2;
  localparam logic [2:0] RPH_L1LAT_SEPARATE_REFCLK_MODE   = 3'h6; // 8 us to 16 us bucket
  localparam int         RPH_L1LAT_SEPARATE_REFCLK_MODE_US = 10;

  // Lane configuration straps
  typedef enum logic [1:0] {
    RPH_CFG_1X4     = 2'h0,
    RPH_CFG_1X2_2X1 = 2'h1,
    RPH_CFG_4X1     = 2'h2,
    RPH_CFG_2X2     = 2'h3
  } rph_lane_cfg_t;

  localparam int RPH_LANES = 4;

  // Strap bundle sampled once after reset
  typedef struct packed {
    logic          separate_refclk_mode;
    logic          lane_rev;
    rph_lane_cfg_t lane_cfg;
  } rph_straps_t;

  // Link-side indications from the physical and data-link layers
  typedef struct packed {
    logic presence;
    logic dll_active;
  } rph_link_t;

  // Init state machine
  typedef enum logic [1:0] {
    RPH_ST_STRAP = 2'b01,
    RPH_ST_RUN   = 2'b10
  } rph_state_t;

endpackage

// ==== src/rph_top.sv ====
// Root port hot-plug, system event and lane configuration logic
//
// Behaviour
// - Insertion sets presence state and changed bits
// - Interrupt only when both enables set
// - Removal clears presence state, sets changed
// - Config-event enable routes events to status
// - Sysmgmt status set only when enabled
// - Presence and link-active changes set sysmgmt bits
// - Any sysmgmt status bit asserts sysmgmt interrupt
// - Sysmgmt bits independent of other enables
// - Sysmgmt interrupt coexists with other interrupts
// - Separate refclk mode from straps only
// - Separate refclk mode tolerates 5600 ppm
// - Separate refclk mode forbids L0s entry
// - Separate refclk mode reports 10 us L1 exit
// - No reduced-rate skip ordered-set scheme
// - Each lane corrects inverted polarity in training
// - Lane reversal maps four lanes end to end
// - Reversal for 1x4 and 2x1+1x2
// - 1x2+2x1 straps plus reversal give 2x1+1x2
// - System error from header or capability bits
module rph_top
  import rph_pkg::*;
#(
  parameter int LANES = rph_pkg::RPH_LANES
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Straps, sampled once after reset
  input  wire rph_pkg::rph_straps_t straps,
  // Link indications from pins and the link layer
  input  wire rph_pkg::rph_link_t   link_in,
  // Per-lane receive polarity seen in training
  input  wire logic [LANES-1:0]     lane_rx_inverted,
  input  wire logic                 training,
  // Error sources
  input  wire logic                 hdr_err_event,
  input  wire logic                 cap_err_event,
  // Event outputs
  output logic                      hotplug_int,
  output logic                      config_event_interrupt,
  output logic                      system_management_int_n,
  output logic                      system_error_n,
  // Port behaviour outputs
  output logic                      l0s_allowed,
  output logic                      lower_skp_enable,
  output logic [LANES-1:0]          lane_polarity_inv,
  output logic [2*LANES-1:0]        lane_map
);

  // Three-stage synchroniser on asynchronous link indications
  rph_link_t s1_q, s2_q, s3_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clk_en) begin
      s1_q <= link_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered levels update only when stages two and three agree
  logic pres_q, pres_d, dlla_q, dlla_d;
  assign pres_d = (s2_q.presence == s3_q.presence) ? s3_q.presence : pres_q;
  assign dlla_d = (s2_q.dll_active == s3_q.dll_active) ?
                  s3_q.dll_active : dlla_q;

  // Strap capture state machine
  rph_state_t  state_q, state_d;
  rph_straps_t strap_q;
  assign state_d = RPH_ST_RUN;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= RPH_ST_STRAP;
      strap_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      unique case (state_q)
        RPH_ST_STRAP: strap_q <= straps;
        RPH_ST_RUN:   strap_q <= strap_q;
      endcase
    end
  end

  wire ready_run = (state_q == RPH_ST_RUN);

  // Event edges; no event until straps captured and filters settled
  logic pres_seen_q;
  wire  pres_edge = ready_run && pres_seen_q && (pres_d != pres_q);
  wire  dlla_edge = ready_run && pres_seen_q && (dlla_d != dlla_q);

  // APB decode
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire sel_ctl = (paddr == RPH_SLOT_CTL_OFS);
  wire sel_sts = (paddr == RPH_SLOT_STS_OFS);
  wire sel_mpc = (paddr == RPH_MISC_CFG_OFS);
  wire sel_sms = (paddr == RPH_SMSC_STS_OFS);
  wire sel_inf = (paddr == RPH_PORT_INFO_OFS);
  wire sel_err = (paddr == RPH_ERR_CTL_OFS);
  wire mapped  = sel_ctl | sel_sts | sel_mpc | sel_sms | sel_inf | sel_err;

  // Control registers
  logic pde_q, hpe_q, hpce_q, hpme_q, hdr_system_error_n_en_q, cap_system_error_n_en_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pde_q         <= 1'b0;
      hpe_q         <= 1'b0;
      hpce_q        <= 1'b0;
      hpme_q        <= 1'b0;
      hdr_system_error_n_en_q <= 1'b0;
      cap_system_error_n_en_q <= 1'b0;
    end else if (clk_en) begin
      if (wr && sel_ctl) begin
        pde_q <= pwdata[RPH_PDE_BIT];
        hpe_q <= pwdata[RPH_HPE_BIT];
      end
      if (wr && sel_mpc) begin
        hpce_q <= pwdata[RPH_HPCE_BIT];
        hpme_q <= pwdata[RPH_HPME_BIT];
      end
      if (wr && sel_err) begin
        hdr_system_error_n_en_q <= pwdata[RPH_HDR_SYSTEM_ERROR_N_BIT];
        cap_system_error_n_en_q <= pwdata[RPH_CAP_SYSTEM_ERROR_N_BIT];
      end
    end
  end

  // Sticky status: a set in the clearing cycle wins over the clear
  wire clr_pdc   = wr && sel_sts && pwdata[RPH_PDC_BIT];
  wire clr_hppdm = wr && sel_sms && pwdata[RPH_HPPDM_BIT];
  wire clr_hplas = wr && sel_sms && pwdata[RPH_HPLAS_BIT];
  wire clr_hpcs  = wr && sel_sms && pwdata[RPH_HPCS_BIT];

  // Enabled presence events and all link-active events route to the configuration-event status
  wire en_event  = (pres_edge && pde_q) || dlla_edge;

  logic pds_q, pdc_q, pdc_d, hppdm_q, hppdm_d, hplas_q, hplas_d;
  logic hpcs_q, hpcs_d;
  assign pdc_d   = pres_edge | (pdc_q & ~clr_pdc);
  assign hppdm_d = (hpme_q & pres_edge) | (hppdm_q & ~clr_hppdm);
  assign hplas_d = (hpme_q & dlla_edge) | (hplas_q & ~clr_hplas);
  assign hpcs_d  = (hpce_q & en_event) | (hpcs_q & ~clr_hpcs);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pres_q      <= 1'b0;
      dlla_q      <= 1'b0;
      pres_seen_q <= 1'b0;
      pds_q       <= 1'b0;
      pdc_q       <= 1'b0;
      hppdm_q     <= 1'b0;
      hplas_q     <= 1'b0;
      hpcs_q      <= 1'b0;
    end else if (clk_en) begin
      pres_q      <= pres_d;
      dlla_q      <= dlla_d;
      pres_seen_q <= ready_run;
      if (pres_edge) begin
        pds_q <= pres_d;
      end
      pdc_q   <= pdc_d;
      hppdm_q <= hppdm_d;
      hplas_q <= hplas_d;
      hpcs_q  <= hpcs_d;
    end
  end

  // Interrupt outputs are independent of one another
  wire int_d  = pdc_q & pde_q & hpe_q;
  wire smi_d  = hppdm_q | hplas_q;
  wire system_error_n_d = (hdr_system_error_n_en_q & hdr_err_event) |
                (cap_system_error_n_en_q & cap_err_event);

  // Lane configuration: reversal is only legal in the two listed configs
  wire rev_ok = strap_q.lane_rev &&
                (strap_q.lane_cfg == RPH_CFG_1X4 ||
                 strap_q.lane_cfg == RPH_CFG_1X2_2X1);

  // Lane map: each two-bit field names the physical lane for logical i
  logic [2*LANES-1:0] map_d;
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      localparam logic [1:0] FWD = 2'(gi);
      localparam logic [1:0] REV = 2'(LANES - 1 - gi);
      assign map_d[2*gi +: 2] = rev_ok ? REV : FWD;
    end
  endgenerate

  // Polarity latched per lane during training only
  logic [LANES-1:0] pol_d;
  assign pol_d = training ? lane_rx_inverted : lane_polarity_inv;

  // Port info read image
  logic [15:0] ppm_tol;
  logic [2:0]  l1_lat;
  assign ppm_tol = strap_q.separate_refclk_mode ? RPH_PPM_SEPARATE_REFCLK_MODE : RPH_PPM_NORMAL;
  assign l1_lat  = strap_q.separate_refclk_mode ? RPH_L1LAT_SEPARATE_REFCLK_MODE : RPH_L1LAT_NORMAL;

  logic [31:0] info_rd;
  always_comb begin
    info_rd = '0;
    info_rd[RPH_SEPARATE_REFCLK_MODE_BIT]            = strap_q.separate_refclk_mode;
    info_rd[RPH_L0S_BIT]             = ~strap_q.separate_refclk_mode;
    info_rd[RPH_LSKP_BIT]            = 1'b0;
    info_rd[RPH_REV_BIT]             = rev_ok;
    info_rd[RPH_CFG_LSB +: 2]        = strap_q.lane_cfg;
    info_rd[RPH_PPM_LSB +: 16]       = ppm_tol;
    info_rd[RPH_L1LAT_LSB +: 3]      = l1_lat;
  end

  // Read mux
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (sel_ctl) begin
      rd_d[RPH_PDE_BIT] = pde_q;
      rd_d[RPH_HPE_BIT] = hpe_q;
    end
    if (sel_sts) begin
      rd_d[RPH_PDC_BIT]  = pdc_q;
      rd_d[RPH_PDS_BIT]  = pds_q;
      rd_d[RPH_DLLA_BIT] = dlla_q;
    end
    if (sel_mpc) begin
      rd_d[RPH_HPCE_BIT] = hpce_q;
      rd_d[RPH_HPME_BIT] = hpme_q;
    end
    if (sel_sms) begin
      rd_d[RPH_HPPDM_BIT] = hppdm_q;
      rd_d[RPH_HPLAS_BIT] = hplas_q;
      rd_d[RPH_HPCS_BIT]  = hpcs_q;
    end
    if (sel_inf) begin
      rd_d = info_rd;
    end
    if (sel_err) begin
      rd_d[RPH_HDR_SYSTEM_ERROR_N_BIT] = hdr_system_error_n_en_q;
      rd_d[RPH_CAP_SYSTEM_ERROR_N_BIT] = cap_system_error_n_en_q;
    end
  end

  // One wait state: pready rises at the end of the first access cycle, so the
  // transfer completes at the second access edge with registered data.
  wire ready_d = acc && !pready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata                  <= '0;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      hotplug_int             <= 1'b0;
      config_event_interrupt  <= 1'b0;
      system_management_int_n <= 1'b1;
      system_error_n          <= 1'b1;
      l0s_allowed             <= 1'b0;
      lower_skp_enable        <= 1'b0;
      lane_polarity_inv       <= '0;
      lane_map                <= '0;
    end else if (clk_en) begin
      pready                  <= ready_d;
      pslverr                 <= ready_d && !mapped;
      prdata                  <= (ready_d && !pwrite) ? rd_d : '0;
      hotplug_int             <= int_d;
      config_event_interrupt  <= hpcs_q;
      system_management_int_n <= ~smi_d;
      system_error_n          <= ~system_error_n_d;
      l0s_allowed             <= ready_run && !strap_q.separate_refclk_mode;
      lower_skp_enable        <= 1'b0;
      lane_polarity_inv       <= pol_d;
      // Held at zero until straps are captured so the map changes only once
      lane_map                <= ready_run ? map_d : '0;
    end
  end

endmodule

// ==== sim/rph_monitor.sv ====
// Port checker for the root port hot-plug block
module rph_monitor
  import rph_pkg::*;
#(
  parameter int LANES = rph_pkg::RPH_LANES
) (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 rst,
  // Bus request and straps
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire rph_pkg::rph_straps_t straps,
  // Lane and error inputs
  input wire logic [LANES-1:0]     lane_rx_inverted,
  input wire logic                 training,
  input wire logic                 hdr_err_event,
  input wire logic                 cap_err_event,
  // Watched outputs
  input wire logic                 system_management_int_n,
  input wire logic                 system_error_n,
  input wire logic                 l0s_allowed,
  input wire logic                 lower_skp_enable,
  input wire logic [LANES-1:0]     lane_polarity_inv,
  input wire logic [2*LANES-1:0]   lane_map
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic wr_sm = psel && penable && pwrite && paddr == RPH_SMSC_STS_OFS;
  wire logic rv_ok = straps.lane_rev && straps.lane_cfg[1] == 1'b0;
  property p_no_l0s; l0s_allowed |-> !straps.separate_refclk_mode; endproperty
  a_no_l0s: assert property (p_no_l0s) else $error("l0s in separate_refclk_mode");
  property p_no_lskp; !lower_skp_enable; endproperty
  a_no_lskp: assert property (p_no_lskp) else $error("lower skp");
  // Strap results may not move until the next reset
  property p_static; lane_map != 8'h00 |=>
    $stable(lane_map) && $stable(l0s_allowed); endproperty
  a_static: assert property (p_static) else $error("strap moved");
  property p_map; lane_map != 8'h00 |-> lane_map inside {8'hE4, 8'h1B};
  endproperty
  a_map: assert property (p_map) else $error("bad lane map");
  property p_rev; lane_map != 8'h00 |-> (lane_map == 8'h1B) == rv_ok;
  endproperty
  a_rev: assert property (p_rev) else $error("reversal wrong");
  property p_pol; training |=>
    lane_polarity_inv == $past(lane_rx_inverted); endproperty
  a_pol: assert property (p_pol) else $error("polarity lost");
  property p_system_error_n; !system_error_n |->
    $past(hdr_err_event || cap_err_event); endproperty
  a_system_error_n: assert property (p_system_error_n) else $error("system_error_n no cause");
  property p_smi_clr; $rose(system_management_int_n) |->
    $past(wr_sm) || $past(wr_sm, 2); endproperty
  a_smi_clr: assert property (p_smi_clr) else $error("smi fell");
endmodule
bind rph_top rph_monitor #(.LANES(LANES)) i_mon (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .straps(straps), .lane_rx_inverted(lane_rx_inverted),
  .training(training), .hdr_err_event(hdr_err_event),
  .cap_err_event(cap_err_event),
  .system_management_int_n(system_management_int_n),
  .system_error_n(system_error_n), .l0s_allowed(l0s_allowed),
  .lower_skp_enable(lower_skp_enable),
  .lane_polarity_inv(lane_polarity_inv), .lane_map(lane_map));

// ==== sim/rph_ep_model.sv ====
// Hot-pluggable endpoint model on the far side of the port
module rph_ep_model
  import rph_pkg::*;
(
  // Clock
  input  wire logic          clock,
  // Bench commands
  input  wire logic          present,
  input  wire logic          up,
  input  wire logic [3:0]    flip,
  // Link side
  output rph_pkg::rph_link_t link,
  output logic [3:0]         rx_inv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial link = '0;
  initial rx_inv = '0;
  // Link layer can only be up on an inserted, powered module
  always @(posedge clock) begin
    link.presence <= present;
    link.dll_active <= present & up;
    rx_inv <= flip;
  end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the root port hot-plug block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rph_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
  logic clock, rst, psel, penable, pwrite, training, hdr_err_event;
  logic present, up, pready, pslverr, err, hotplug_int, cfg_int, smi_n;
  logic system_error_n_n, l0s_allowed, lskp, s, rv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [3:0] rx_inv, pol_inv, flip, en;
  logic [7:0] lane_map;
  rph_straps_t straps;
  rph_link_t link_in;
  int fail_count, num_checks, pds, pdc, la, smp, sml, hpc;
  rph_top i_dut (.clock(clock), .rst(rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .straps(straps),
    .link_in(link_in), .lane_rx_inverted(rx_inv), .training(training),
    .hdr_err_event(hdr_err_event), .cap_err_event(1'b0),
    .hotplug_int(hotplug_int), .config_event_interrupt(cfg_int),
    .system_management_int_n(smi_n), .system_error_n(system_error_n_n),
    .l0s_allowed(l0s_allowed), .lower_skp_enable(lskp),
    .lane_polarity_inv(pol_inv), .lane_map(lane_map));
  rph_ep_model i_ep (.clock(clock), .present(present), .up(up),
    .flip(flip), .link(link_in), .rx_inv(rx_inv));
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads go first so that registered outputs have settled
  task automatic chk();
    apb(1'b0, RPH_SLOT_STS_OFS, 32'h0);
    `CHK({rd[8], rd[6], rd[3]}, {la[0], pds[0], pdc[0]})
    apb(1'b0, RPH_SMSC_STS_OFS, 32'h0);
    `CHK(rd[3:1], {hpc[0], sml[0], smp[0]})
    `CHK(hotplug_int, pdc[0] & en[0] & en[1])
    `CHK({cfg_int, smi_n}, {hpc[0], ~(smp[0] | sml[0])})
  endtask
  task automatic ev(input int p, input int u);
    @(posedge clock);
    present <= p[0];
    up <= u[0];
    repeat (10) @(posedge clock);
    if (p != pds) begin
      pdc = 1;
      pds = p;
      smp |= en[3];
      hpc |= en[2] & en[0];
    end
    if (u != la) begin
      la = u;
      sml |= en[3];
      hpc |= en[2];
    end
    chk();
  endtask
  task automatic clr();
    apb(1'b1, RPH_SMSC_STS_OFS, 32'h0000_000E);
    apb(1'b1, RPH_SLOT_STS_OFS, 32'h0000_0008);
    {smp, sml, hpc, pdc} = '0;
    chk();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (8000) @(posedge clock);
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [3:0] st [3] = '{4'h6, 4'hD, 4'h4};
    logic [3:0] ens [3] = '{4'hF, 4'h8, 4'h7};
    {psel, penable, pwrite, paddr, pwdata, training} = '0;
    {hdr_err_event, present, up, flip, straps} = '0;
    rst = 1'b1;
    void'($urandom(32'hE146));
    for (int i = 0; i < 3; i++) begin
      straps <= st[i];
      en = ens[i];
      rst <= 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      {pds, pdc, la, smp, sml, hpc} = '0;
      repeat (4) @(posedge clock);
      s = st[i][3];
      rv = st[i][2] && !st[i][1];
      ex = {5'h0, s ? RPH_L1LAT_SEPARATE_REFCLK_MODE : RPH_L1LAT_NORMAL,
            s ? RPH_PPM_SEPARATE_REFCLK_MODE : RPH_PPM_NORMAL, 2'b00, st[i][1:0],
            rv, 1'b0, ~s, s};
      apb(1'b0, RPH_PORT_INFO_OFS, 32'h0);
      `CHK(rd, ex)
      `CHK({l0s_allowed, lskp}, {~s, 1'b0})
      `CHK(lane_map, rv ? 8'h1B : 8'hE4)
      apb(1'b1, RPH_SLOT_CTL_OFS, {26'h0, en[1], 1'b0, en[0], 3'h0});
      apb(1'b1, RPH_MISC_CFG_OFS, {29'h0, en[3:2], 1'b0});
      apb(1'b1, RPH_ERR_CTL_OFS, 32'h0000_0001);
      flip <= 4'($urandom);
      training <= 1'b1;
      repeat (4) @(posedge clock);
      training <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK(pol_inv, flip)
      ev(1, 0);
      ev(1, 1);
      clr();
      ev(0, 0);
      clr();
      hdr_err_event <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK(system_error_n_n, 1'b0)
      hdr_err_event <= 1'b0;
      apb(1'b0, 12'hFFC, 32'h0);
      `CHK({err, system_error_n_n, rd}, {2'b11, 32'h0})
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule
